// ---- pkg/sssp_pkg.sv ----
// Purpose: Shared constants and types for the synchronous serial shift port
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Offsets, field positions and reset values live here only
package sssp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SR_W   = 8;
  localparam int CNT_W  = 4;

  // Clock figures, in ns, and the instruction cycle in pclk cycles
  localparam int PCLK_NS   = 5;
  localparam int TC_NS     = 10;
  localparam int TC_CYCLES = (TC_NS + PCLK_NS - 1) / PCLK_NS;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PGD  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PGC  = 8'h10;

  // Field positions
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_CNT_POS  = 1;
  localparam int PGD_IDLE_POS  = 5;
  localparam int PGC_LSB_POS   = 4;

  // Bit count at which a full byte has moved
  localparam logic [CNT_W-1:0] FULL_COUNT = 4'h8;

  typedef struct packed {
    logic irq_en;
    logic rate_sel_high;
    logic rate_sel_low;
    logic port_select_bit;
  } ctrl_t;

  // Port G configuration bits 6..4
  typedef struct packed {
    logic edge_select_flag;
    logic clk_int_cfg;
    logic sdo_cfg;
  } pgc_t;

  localparam ctrl_t             CTRL_RST = '0;
  localparam pgc_t              PGC_RST  = '0;
  localparam logic              IDLE_RST = 1'b0;
  localparam logic [SR_W-1:0]   SR_RST   = 8'h00;

endpackage

// ---- src/sssp_sync2.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module sssp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ---- src/shift_clk_div.sv ----
// Purpose: Half-period enable for the master shift clock
// Assumes: rate code 00, 01, 1x selects 2, 4, 8 instruction cycles per period
// Notes:   Counter restarts whenever run drops
`timescale 1ns/100ps
`default_nettype none
module shift_clk_div #(
  parameter int TC_CYCLES = sssp_pkg::TC_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            half_en
);

  logic [7:0] cnt_ff;
  wire  [7:0] half_len;
  wire        wrap;

  // Half of 2, 4 or 8 instruction cycles
  assign half_len = rate[1] ? 8'(4 * TC_CYCLES) :
                    rate[0] ? 8'(2 * TC_CYCLES) : 8'(TC_CYCLES);
  assign wrap     = (cnt_ff == half_len - 8'h01);
  assign half_en  = run & wrap;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 8'h00;
    else if (!run || wrap)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end

endmodule
`default_nettype wire

// ---- src/sync_serial_shift_port.sv ----
// Summary of operation
// - Eight-bit shift register on data and clock pins
// - Internal clock means master, external means slave
// - Port works only while port select is set
// - Rate code sets period: 2, 4, 8 cycles
// - Writing busy starts; cleared after eight bits
// - Clearing busy early stops the shift
// - Completion raises interrupt request when enabled
// - Master makes the clock and starts exchanges
// - Clock stops after eight pulses
// - Pin config bits pick output and clock source
// - Slave busy set early; cleared after eight
// - Port G data bit five sets idle level
// - Normal phase: sample rising, shift falling
// - Alternate phase: sample falling, output rising
// - Port G config bit six picks phase
// - Edge choice follows XOR of both bits
// - Edge select flag resets cleared
//
// Purpose: Synchronous serial shift port with APB register access
// Assumes: pclk 200 MHz; pins are asynchronous and pass two flops
// Notes:   Master input is sampled late by the synchroniser delay,
//          so the far end must hold data for a half period
`timescale 1ns/100ps
`default_nettype none
module sync_serial_shift_port #(
  parameter int TC_CYCLES = sssp_pkg::TC_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sssp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sssp_pkg::DATA_W-1:0] pwdata,
  output logic      [sssp_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sdi_pin,
  input  wire logic                        shift_clock_pin_i,
  output logic                             shift_clock_pin_o,
  output logic                             shift_clock_pin_oe_n,
  output logic                             sdo_pin_o,
  output logic                             sdo_pin_oe_n,
  output logic                             shift_done_irq
);
  import sssp_pkg::*;

  ctrl_t              ctrl_ff;
  pgc_t               pgc_ff;
  logic               idle_hi_ff;
  logic               busy_ff;
  logic [CNT_W-1:0]   cnt_ff;
  logic [SR_W-1:0]    serial_shift_reg_ff;
  logic               sdo_ff;
  logic               sck_ff;
  logic               prev_ff;
  logic               irq_ff;
  logic [DATA_W-1:0]  prdata_ff;

  logic               nxt_busy;
  logic [CNT_W-1:0]   nxt_cnt;
  logic [SR_W-1:0]    nxt_sr;
  logic               nxt_sdo;
  logic               nxt_sck;

  logic               sck_s;
  logic               sdi_s;
  logic               half_en;

  // Bus decode
  wire wr_acc   = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_stat = (paddr == OFF_STAT);
  wire hit_data = (paddr == OFF_DATA);
  wire hit_pgd  = (paddr == OFF_PGD);
  wire hit_pgc  = (paddr == OFF_PGC);
  wire mapped   = hit_ctrl | hit_stat | hit_data | hit_pgd | hit_pgc;

  // Mode and phase selection
  wire port_on  = ctrl_ff.port_select_bit;
  wire master   = port_on & pgc_ff.clk_int_cfg;
  wire idle_lvl = idle_hi_ff;
  wire out_fall = ~(pgc_ff.edge_select_flag ^ idle_hi_ff);
  wire [1:0] rate_code = {ctrl_ff.rate_sel_high, ctrl_ff.rate_sel_low};

  // Edge detection on whichever clock drives the shifter
  wire cur_sck  = master ? sck_ff : sck_s;
  wire rise     = busy_ff & cur_sck & ~prev_ff;
  wire fall     = busy_ff & ~cur_sck & prev_ff;
  wire samp     = out_fall ? rise : fall;
  wire shft     = out_fall ? fall : rise;

  // Transfer control
  wire done     = busy_ff & (cnt_ff == FULL_COUNT) & (cur_sck == idle_lvl);
  wire start    = wr_acc & hit_stat & pwdata[STAT_BUSY_POS] & port_on;
  wire abort    = wr_acc & hit_stat & ~pwdata[STAT_BUSY_POS];
  wire wr_data  = wr_acc & hit_data;
  wire run      = busy_ff & master & ~done;

  // Read data mux
  wire [DATA_W-1:0] rd_ctrl = DATA_W'(ctrl_ff);
  wire [DATA_W-1:0] rd_stat = DATA_W'({cnt_ff, busy_ff});
  wire [DATA_W-1:0] rd_data = DATA_W'(serial_shift_reg_ff);
  wire [DATA_W-1:0] rd_pgd  = DATA_W'(idle_hi_ff) << PGD_IDLE_POS;
  wire [DATA_W-1:0] rd_pgc  = DATA_W'(pgc_ff) << PGC_LSB_POS;
  wire [DATA_W-1:0] rd_mux  = hit_ctrl ? rd_ctrl :
                              hit_stat ? rd_stat :
                              hit_data ? rd_data :
                              hit_pgd  ? rd_pgd  :
                              hit_pgc  ? rd_pgc  : '0;

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Pins: enables are low while driving
  assign shift_clock_pin_o    = sck_ff;
  assign shift_clock_pin_oe_n = ~master;
  assign sdo_pin_o            = sdo_ff;
  assign sdo_pin_oe_n         = ~(port_on & pgc_ff.sdo_cfg);
  assign shift_done_irq       = irq_ff;

  sssp_sync2 #(
    .W (2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({shift_clock_pin_i, sdi_pin}),
    .q       ({sck_s, sdi_s})
  );

  shift_clk_div #(
    .TC_CYCLES (TC_CYCLES)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .rate    (rate_code),
    .half_en (half_en)
  );

  // Next-state logic
  always_comb
  begin
    // Software set wins over the hardware clear
    nxt_busy = start | (busy_ff & ~done & ~abort & port_on);
    nxt_cnt  = cnt_ff;
    if (start)
      nxt_cnt = '0;
    else if (samp)
      nxt_cnt = cnt_ff + 4'h1;
    nxt_sr = serial_shift_reg_ff;
    if (wr_data)
      nxt_sr = pwdata[SR_W-1:0];
    else if (samp)
      nxt_sr = {serial_shift_reg_ff[SR_W-2:0], sdi_s};
    nxt_sdo = sdo_ff;
    if (wr_data)
      nxt_sdo = pwdata[SR_W-1];
    else if (start || shft)
      nxt_sdo = serial_shift_reg_ff[SR_W-1];
    // Master clock toggles only inside a transfer
    if (run)
      nxt_sck = sck_ff ^ half_en;
    else
      nxt_sck = idle_lvl;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff    <= CTRL_RST;
      pgc_ff     <= PGC_RST;
      idle_hi_ff <= IDLE_RST;
    end
    else if (wr_acc)
    begin
      if (hit_ctrl)
        ctrl_ff <= ctrl_t'(pwdata[3:0]);
      if (hit_pgd)
        idle_hi_ff <= pwdata[PGD_IDLE_POS];
      if (hit_pgc)
        pgc_ff <= pgc_t'(pwdata[PGC_LSB_POS +: 3]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_ff             <= 1'b0;
      cnt_ff              <= '0;
      serial_shift_reg_ff <= SR_RST;
      sdo_ff              <= 1'b0;
    end
    else
    begin
      busy_ff             <= nxt_busy;
      cnt_ff              <= nxt_cnt;
      serial_shift_reg_ff <= nxt_sr;
      sdo_ff              <= nxt_sdo;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_ff  <= IDLE_RST;
      prev_ff <= IDLE_RST;
      irq_ff  <= 1'b0;
    end
    else
    begin
      sck_ff  <= nxt_sck;
      prev_ff <= cur_sck;
      irq_ff  <= done & ctrl_ff.irq_en;
    end
  end

  // Read data is caught in the setup cycle, so the slave needs no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (rd_setup)
      prdata_ff <= rd_mux;
  end

  // Checks

  sequence s_start;
    wr_acc && hit_stat && pwdata[STAT_BUSY_POS] && port_on;
  endsequence

  sequence s_fresh;
    busy_ff && (cnt_ff == '0);
  endsequence

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    s_start |=> s_fresh;
  endproperty

  a_busy_start_set: assert property (p_start)
    else $error("busy not set with zero count after start");

  a_busy_self_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    done && !start |=> !busy_ff)
    else $error("busy still set after eight bits");

  a_busy_abort_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    abort |=> !busy_ff ##1 $stable(cnt_ff))
    else $error("shifting continued after abort");

  a_port_off_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !port_on |-> (shift_clock_pin_oe_n && sdo_pin_oe_n) ##1 !busy_ff)
    else $error("port active without port select");

  a_count_limit: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy_ff |-> cnt_ff <= FULL_COUNT)
    else $error("more than eight bits counted");

  a_irq_on_done: assert property (
    @(posedge pclk) disable iff (!presetn)
    shift_done_irq |-> $past(done) && $past(ctrl_ff.irq_en))
    else $error("interrupt without enabled completion");

  a_sck_idle_rest: assert property (
    @(posedge pclk) disable iff (!presetn)
    !busy_ff && $stable(idle_hi_ff) |=> shift_clock_pin_o == $past(idle_hi_ff))
    else $error("master clock not at idle level");

  a_sck_rate_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    master && $changed(sck_ff) && $past(busy_ff) && $past(run) |-> $past(half_en))
    else $error("master clock toggled off the divider tick");

  a_slave_no_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy_ff && !master |-> shift_clock_pin_oe_n && $stable(sck_ff) || !$past(master))
    else $error("slave drives the clock pin");

  a_shift_lsb_in: assert property (
    @(posedge pclk) disable iff (!presetn)
    samp && !wr_data |=> serial_shift_reg_ff[0] == $past(sdi_s))
    else $error("sampled bit not at lsb");

  a_edge_phase: assert property (
    @(posedge pclk) disable iff (!presetn)
    samp |-> (out_fall ? cur_sck : !cur_sck))
    else $error("sample on wrong clock edge");

  sequence s_full_byte;
    busy_ff && (cnt_ff == FULL_COUNT) && (cur_sck == idle_lvl);
  endsequence

  sequence s_quiet_after;
    !busy_ff && shift_done_irq;
  endsequence

  // A restart in the completion cycle keeps busy, so it is left out here
  property p_done_irq;
    @(posedge pclk) disable iff (!presetn)
    s_full_byte ##0 (ctrl_ff.irq_en && !start) |=> s_quiet_after;
  endproperty

  a_done_irq_pulse: assert property (p_done_irq)
    else $error("no interrupt pulse on completion");

  a_irq_off_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_ff.irq_en |=> !shift_done_irq)
    else $error("interrupt raised while disabled");

  a_sdo_msb_first: assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> sdo_pin_o == $past(serial_shift_reg_ff[SR_W-1]))
    else $error("first output bit is not the msb");

  a_sdo_hold_still: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy_ff && !shft && !start && !wr_data |=> $stable(sdo_pin_o))
    else $error("output bit changed off the output edge");

  a_idle_count_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !busy_ff |=> $stable(cnt_ff) || $past(start))
    else $error("bit count moved while not busy");

  a_master_drives_clk: assert property (
    @(posedge pclk) disable iff (!presetn)
    port_on && pgc_ff.clk_int_cfg |-> !shift_clock_pin_oe_n)
    else $error("master does not drive the clock pin");

endmodule
`default_nettype wire

// ---- verif/sssp_peer.sv ----
// Purpose: Far-side serial peer for the shift port bench
// Assumes: The bench resolves the clock wire and feeds it back here
// Notes:   Own clock runs only inside a frame and rests at idle
`timescale 1ns/100ps
`default_nettype none
module sssp_peer (
  input  wire logic sck,
  input  wire logic sdo,
  input  wire logic x,
  output logic      sdi,
  output logic      sck_drv
);
  logic [7:0] tx;
  logic [7:0] rx;
  int         ns;

  initial
  begin
    tx = 8'h00;
    rx = 8'h00;
    ns = 0;
    sck_drv = 1'b0;
  end

  assign sdi = tx[7];

  // No shift before the first sample, so a leading output edge keeps the MSB
  always @(sck)
  begin
    if ((sck ^ x) === 1'b1)
    begin
      rx <= {rx[6:0], sdo};
      ns <= ns + 1;
    end
    else if (ns > 0)
      tx <= {tx[6:0], ~tx[0]};
  end

  task automatic load(input logic [7:0] b);
    tx = b;
    ns = 0;
  endtask

  // Frame starts from idle, so no narrowed first pulse
  task automatic gen(input int n, input logic idle);
    sck_drv = idle;
    repeat (n)
    begin
      #32 sck_drv = ~idle;
      #32 sck_drv = idle;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/sync_serial_shift_port_tb.sv ----
// Purpose: Self-checking bench for the synchronous serial shift port
// Assumes: Zero-wait APB; peer model on the serial pins
// Notes:   TC_CYCLES raised so master sampling lag fits a half period
`timescale 1ns/100ps
`default_nettype none
module sync_serial_shift_port_tb;
  import sssp_pkg::*;
  localparam int TCN = 5;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sdi;
  logic        sck_o;
  logic        sck_oe_n;
  logic        sdo_o;
  logic        sdo_oe_n;
  logic        irq;
  logic        sck_drv;
  logic        sck_q;
  logic        pk_x;
  logic        gbad;
  logic [31:0] rq;
  logic        re;
  int          errors;
  int          num_checks;
  int          tog;
  int          gap;
  int          hexp;
  int          irqs;
  int          cyc;
  wire         sck_w;
  wire         sdo_w;

  assign sck_w = sck_oe_n ? sck_drv : sck_o;
  assign sdo_w = sdo_oe_n ? 1'bz : sdo_o;

  sync_serial_shift_port #(.TC_CYCLES(TCN)) sync_serial_shift_port_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sdi_pin(sdi), .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
    .shift_clock_pin_oe_n(sck_oe_n), .sdo_pin_o(sdo_o), .sdo_pin_oe_n(sdo_oe_n),
    .shift_done_irq(irq));

  sssp_peer sssp_peer_i (.sck(sck_w), .sdo(sdo_w), .x(pk_x), .sdi(sdi), .sck_drv(sck_drv));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Toggle spacing, irq pulses and the hang limit
  always @(posedge pclk)
  begin
    gap = gap + 1;
    cyc = cyc + 1;
    if (irq === 1'b1)
      irqs = irqs + 1;
    if (sck_o !== sck_q)
    begin
      if (tog > 0 && gap != hexp)
        gbad = 1'b1;
      tog = tog + 1;
      gap = 0;
    end
    sck_q = sck_o;
    if (cyc == 40000)
    begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic poll;
    int n;
    n = 0;
    rd(OFF_STAT);
    while (rq[0] === 1'b1 && n < 800)
    begin
      rd(OFF_STAT);
      n = n + 1;
    end
  endtask

  task automatic t_reset;
    rd(OFF_CTRL);
    chk(rq, 32'h0);
    rd(OFF_PGC);
    chk(rq, 32'h0);
    rd(OFF_STAT);
    chk(rq, 32'h0);
    chk(32'({sck_oe_n, sdo_oe_n, sck_o}), 32'h6);
    rd(8'h14);
    chk(32'(re), 32'h1);
    $display("done reset");
  endtask

  task automatic t_master(input logic [1:0] r, input logic e, input logic i, input logic ie,
                          input logic [7:0] s, input logic [7:0] p);
    wr(OFF_CTRL, {28'h0, ie, r, 1'b1});
    wr(OFF_PGD, {26'h0, i, 5'h0});
    wr(OFF_PGC, {25'h0, e, 2'b11, 4'h0});
    wr(OFF_DATA, {24'h0, s});
    pk_x = e ^ i;
    sssp_peer_i.load(p);
    chk(32'(sck_w), 32'(i));
    tog = 0;
    irqs = 0;
    gbad = 1'b0;
    hexp = TCN * ((r == 2'b00) ? 1 : (r == 2'b01) ? 2 : 4);
    wr(OFF_STAT, 32'h1);
    poll();
    chk(32'(rq[0]), 32'h0);
    chk(32'(tog), 32'd16);
    chk(32'(gbad), 32'h0);
    chk(32'(irqs), 32'(ie));
    chk(32'(sck_w), 32'(i));
    chk(32'(sssp_peer_i.rx), 32'(s));
    rd(OFF_DATA);
    chk(rq, 32'(p));
    $display("done master");
  endtask

  task automatic t_abort(input logic [7:0] s, input logic [7:0] p);
    int n;
    wr(OFF_CTRL, 32'hd);
    wr(OFF_PGD, 32'h0);
    wr(OFF_PGC, 32'h30);
    wr(OFF_DATA, 32'(s));
    pk_x = 1'b0;
    sssp_peer_i.load(p);
    tog = 0;
    irqs = 0;
    hexp = 4 * TCN;
    wr(OFF_STAT, 32'h1);
    n = 0;
    while (tog < 6 && n < 1000)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    wr(OFF_STAT, 32'h0);
    n = tog;
    repeat (100) @(posedge pclk);
    chk(32'(tog), 32'(n));
    chk(32'(irqs), 32'h0);
    rd(OFF_STAT);
    chk(32'(rq[0]), 32'h0);
    rd(OFF_DATA);
    chk(rq, {24'h0, s[4:0], p[7:5]});
    $display("done abort");
  endtask

  task automatic t_slave(input logic e, input logic i, input logic [7:0] s, input logic [7:0] p);
    wr(OFF_CTRL, 32'h9);
    wr(OFF_PGD, {26'h0, i, 5'h0});
    wr(OFF_PGC, {25'h0, e, 2'b01, 4'h0});
    pk_x = e ^ i;
    chk(32'({sck_oe_n, sdo_oe_n}), 32'h2);
    wr(OFF_DATA, 32'(s));
    sssp_peer_i.gen(2, i);
    rd(OFF_DATA);
    chk(rq, 32'(s));
    sssp_peer_i.load(p);
    irqs = 0;
    wr(OFF_STAT, 32'h1);
    sssp_peer_i.gen(8, i);
    poll();
    chk(32'(rq[0]), 32'h0);
    chk(32'(irqs), 32'h1);
    chk(32'(sssp_peer_i.rx), 32'(s));
    rd(OFF_DATA);
    chk(rq, 32'(p));
    $display("done slave");
  endtask

  task automatic t_portsel;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PGC, 32'h30);
    tog = 0;
    wr(OFF_STAT, 32'h1);
    rd(OFF_STAT);
    chk(32'(rq[0]), 32'h0);
    chk(32'({sck_oe_n, sdo_oe_n, 4'(tog)}), 32'h30);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_PGC, 32'h20);
    chk(32'({sck_oe_n, sdo_oe_n}), 32'h1);
    $display("done portsel");
  endtask

  initial
  begin
    errors = 0;
    num_checks = 0;
    tog = 0;
    gap = 0;
    hexp = 0;
    irqs = 0;
    cyc = 0;
    gbad = 1'b0;
    sck_q = 1'b0;
    pk_x = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_master(2'b00, 1'b0, 1'b0, 1'b1, 8'ha5, 8'h3c);
    t_master(2'b01, 1'b1, 1'b0, 1'b1, 8'h80, 8'h01);
    t_master(2'b10, 1'b0, 1'b1, 1'b0, 8'h01, 8'hfe);
    t_master(2'b11, 1'b1, 1'b1, 1'b0, 8'h96, 8'h69);
    t_abort(8'hc6, 8'h5a);
    t_slave(1'b1, 1'b0, 8'h4d, 8'hb2);
    t_slave(1'b1, 1'b1, 8'he1, 8'h1e);
    t_portsel();
    wrap_up();
  end
endmodule
`default_nettype wire
